// file: verilog/it_params.svh
// constants for the instruction timing decoder: opcode fields,
// group codes, byte lengths and clock counts.
// assumes the classic accumulator opcode map on an 8-bit opcode.
`ifndef IT_PARAMS_SVH
`define IT_PARAMS_SVH

// opcode field positions
`define IT_HI_MSB      7
`define IT_HI_LSB      4
`define IT_LO_MSB      3
`define IT_LO_LSB      0

// high-nibble operation groups
`define IT_GRP_INC     4'h0
`define IT_GRP_DEC     4'h1
`define IT_GRP_ADD     4'h2
`define IT_GRP_ADDC    4'h3
`define IT_GRP_ORL     4'h4
`define IT_GRP_ANL     4'h5
`define IT_GRP_XRL     4'h6
`define IT_GRP_SUBB    4'h9

// low-nibble operand forms
`define IT_LO_JMP11    4'h1
`define IT_LO_DIRA     4'h2
`define IT_LO_DIRIMM   4'h3
`define IT_LO_IMM      4'h4
`define IT_LO_DIR      4'h5
`define IT_LO_IND      3'h3

// single opcodes with their own timing
`define IT_OP_MUL      8'hA4
`define IT_OP_DIV      8'h84
`define IT_OP_INCDP    8'hA3
`define IT_OP_DECADJ   8'hD4
`define IT_OP_RSVD     8'hA5

// distinct instruction forms of the set
`define IT_NUM_INSTR   109

// program bytes
`define IT_B1          2'h1
`define IT_B2          2'h2
`define IT_B3          2'h3

// clock counts
`define IT_C0          4'h0
`define IT_C1          4'h1
`define IT_C2          4'h2
`define IT_C3          4'h3
`define IT_C4          4'h4
`define IT_C5          4'h5
`define IT_C8          4'h8
`define IT_MAX_CLKS    4'h8

`endif

// file: verilog/it_pkg.sv
// types shared by the instruction timing decoder.
// assumes it_params.svh supplies the numeric constants.
package it_pkg;

	// instruction class
	typedef enum logic [2:0] {
		cls_other  = 3'h0,
		cls_arith  = 3'h1,
		cls_logic  = 3'h2,
		cls_muldiv = 3'h3,
		cls_branch = 3'h4
	} class_e;

	// sequencer states, gray along idle-busy-final
	typedef enum logic [1:0] {
		st_idle  = 2'h0,
		st_busy  = 2'h1,
		st_final = 2'h3
	} state_e;

	// decoded timing of one instruction
	typedef struct packed {
		logic        illegal;
		class_e      cls;
		logic        cond;
		logic [1:0]  nbytes;
		logic [3:0]  nclk;
	} timing_s;

endpackage

// file: verilog/instr_timing.sv
// opcode timing decoder and clock-cycle sequencer of the core.
// assumes opcode, valid and branch outcome come from core logic on
// mclk_in, so no synchroniser is needed on them.
`timescale 1ns/100ps
`include "it_params.svh"

module instr_timing
	import it_pkg::*;
(
	// clock and reset
	input  wire logic          mclk_in,
	input  wire logic          reset_in,
	// instruction offer
	input  wire logic [7:0]    opcode_in,
	input  wire logic          opcode_valid_in,
	input  wire logic          branch_taken_in,
	output logic               ready_out,
	// execution progress
	output timing_s            timing_out,
	output logic [3:0]         remain_out,
	output logic               busy_out,
	output logic               done_out
);

	////////////////////////////////////////////////////////////////
	// decode helpers

	// arithmetic groups share one operand-form layout
	function automatic logic is_arith(input logic [3:0] hi);
		is_arith = (hi == `IT_GRP_ADD) || (hi == `IT_GRP_ADDC) ||
			(hi == `IT_GRP_SUBB) || (hi == `IT_GRP_INC) ||
			(hi == `IT_GRP_DEC);
	endfunction

	// logical groups have two extra direct-destination forms
	function automatic logic is_logic(input logic [3:0] hi);
		is_logic = (hi == `IT_GRP_ORL) || (hi == `IT_GRP_ANL) ||
			(hi == `IT_GRP_XRL);
	endfunction

	// operand form in the low nibble, rows x6 to xF
	function automatic logic is_reg(input logic [3:0] lo);
		is_reg = lo[3];
	endfunction

	function automatic logic is_ind(input logic [3:0] lo);
		is_ind = (lo[3:1] == `IT_LO_IND);
	endfunction

	function automatic timing_s decode(input logic [7:0] op);
		logic [3:0] hi;
		logic [3:0] lo;
		logic       incdec;
		timing_s    t;
		hi = op[`IT_HI_MSB:`IT_HI_LSB];
		lo = op[`IT_LO_MSB:`IT_LO_LSB];
		incdec = (hi == `IT_GRP_INC) || (hi == `IT_GRP_DEC);
		t = '{illegal: 1'b0, cls: cls_other, cond: 1'b0,
			nbytes: `IT_B1, nclk: `IT_C1};
		// one byte, one clock unless a form below says otherwise
		if (op == `IT_OP_RSVD) begin
			t.illegal = 1'b1;
		end else if (op == `IT_OP_MUL) begin
			t.cls = cls_muldiv;
			t.nclk = `IT_C4;
		end else if (op == `IT_OP_DIV) begin
			t.cls = cls_muldiv;
			t.nclk = `IT_C8;
		end else if (op == `IT_OP_INCDP || op == `IT_OP_DECADJ) begin
			t.cls = cls_arith;
		end else if ((is_arith(hi) || is_logic(hi)) && lo >= `IT_LO_IMM) begin
			t.cls = is_arith(hi) ? cls_arith : cls_logic;
			if (is_reg(lo)) begin
				{t.nbytes, t.nclk} = {`IT_B1, `IT_C1};
			end else if (is_ind(lo)) begin
				{t.nbytes, t.nclk} = {`IT_B1, `IT_C2};
			end else if (lo == `IT_LO_IMM && incdec) begin
				{t.nbytes, t.nclk} = {`IT_B1, `IT_C1};
			end else begin
				{t.nbytes, t.nclk} = {`IT_B2, `IT_C2};
			end
		end else if (is_logic(hi) && lo == `IT_LO_DIRA) begin
			t.cls = cls_logic;
			{t.nbytes, t.nclk} = {`IT_B2, `IT_C2};
		end else if (is_logic(hi) && lo == `IT_LO_DIRIMM) begin
			t.cls = cls_logic;
			{t.nbytes, t.nclk} = {`IT_B3, `IT_C3};
		end else if (lo == `IT_LO_JMP11) begin
			// absolute jump and call: two bytes, three clocks
			t.cls = cls_branch;
			{t.nbytes, t.nclk} = {`IT_B2, `IT_C3};
		end else begin
			// remaining classic forms; clocks track bytes by default
			case (op)
				8'h40, 8'h50, 8'h60, 8'h70,
				8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF: begin
					// carry/zero tests and register count-down loop
					t.cls = cls_branch;
					t.cond = 1'b1;
					{t.nbytes, t.nclk} = {`IT_B2, `IT_C2};
				end
				8'h10, 8'h20, 8'h30, 8'hD5, 8'hB4, 8'hB5,
				8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF: begin
					t.cls = cls_branch;
					t.cond = 1'b1;
					{t.nbytes, t.nclk} = {`IT_B3, `IT_C3};
				end
				8'hB6, 8'hB7: begin
					t.cls = cls_branch;
					t.cond = 1'b1;
					{t.nbytes, t.nclk} = {`IT_B3, `IT_C4};
				end
				8'h02, 8'h12: begin
					t.cls = cls_branch;
					{t.nbytes, t.nclk} = {`IT_B3, `IT_C4};
				end
				8'h80: begin
					t.cls = cls_branch;
					{t.nbytes, t.nclk} = {`IT_B2, `IT_C3};
				end
				8'h22, 8'h32: begin
					t.cls = cls_branch;
					t.nclk = `IT_C5;
				end
				8'h73, 8'h83, 8'h93, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: begin
					t.cls = (op == 8'h73) ? cls_branch : cls_other;
					t.nclk = `IT_C3;
				end
				8'hE6, 8'hE7, 8'hF6, 8'hF7, 8'hC6, 8'hC7, 8'hD6, 8'hD7: begin
					t.nclk = `IT_C2;
				end
				8'h75, 8'h85, 8'h90: begin
					{t.nbytes, t.nclk} = {`IT_B3, `IT_C3};
				end
				8'h72, 8'h82, 8'h92, 8'hA0, 8'hA2, 8'hB0, 8'hB2, 8'hC2, 8'hD2,
				8'h74, 8'h76, 8'h77, 8'h86, 8'h87, 8'hA6, 8'hA7,
				8'hC0, 8'hD0, 8'hC5, 8'hE5, 8'hF5: begin
					{t.nbytes, t.nclk} = {`IT_B2, `IT_C2};
				end
				default: begin
					// register moves with a second operand byte
					if (is_reg(lo) && (hi == 4'h7 || hi == 4'h8 || hi == 4'hA))
						{t.nbytes, t.nclk} = {`IT_B2, `IT_C2};
				end
			endcase
		end
		decode = t;
	endfunction

	////////////////////////////////////////////////////////////////
	// decode and run length

	state_e     state_r;
	state_e     state_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	timing_s    dec;
	timing_s    tim_nxt;
	logic [3:0] run_clk;
	logic       accept;

	// a taken conditional branch costs one clock more
	assign dec     = decode(opcode_in);
	assign run_clk = dec.nclk + {3'h0, dec.cond & branch_taken_in};
	assign accept  = opcode_valid_in & ready_out;
	assign tim_nxt = '{illegal: dec.illegal, cls: dec.cls, cond: dec.cond,
		nbytes: dec.nbytes, nclk: run_clk};

	// next instruction may issue in the last clock of the current one,
	// which is what gives one instruction per clock at peak
	assign ready_out = (state_r != st_busy);

	////////////////////////////////////////////////////////////////
	// sequencer: one count per clock, no machine-cycle grouping

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			st_idle, st_final: begin
				if (accept) begin
					cnt_nxt   = run_clk;
					state_nxt = (run_clk == `IT_C1) ? st_final : st_busy;
				end else begin
					cnt_nxt   = `IT_C0;
					state_nxt = st_idle;
				end
			end
			st_busy: begin
				cnt_nxt = cnt_r - `IT_C1;
				if (cnt_r == `IT_C2)
					state_nxt = st_final;
			end
			default: begin
				cnt_nxt   = `IT_C0;
				state_nxt = st_idle;
			end
		endcase
	end

	// state, remaining count and latched timing
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			state_r    <= st_idle;
			cnt_r      <= `IT_C0;
			timing_out <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			if (accept)
				timing_out <= tim_nxt;
		end
	end

	// status views of the registered state
	assign remain_out = cnt_r;
	assign busy_out   = (state_r != st_idle);
	assign done_out   = (state_r == st_final);

	////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);

	property p_reg_arith;
		accept && is_arith(opcode_in[7:4]) && opcode_in[3] |=> done_out;
	endproperty
	a_reg_arith: assert property (p_reg_arith)
		else $error("register arithmetic not done in one clock");

	property p_ind_arith;
		accept && is_arith(opcode_in[7:4]) && is_ind(opcode_in[3:0])
			|=> !done_out ##1 done_out && timing_out.nbytes == `IT_B1;
	endproperty
	a_ind_arith: assert property (p_ind_arith)
		else $error("indirect arithmetic not two clocks");

	property p_dir_arith;
		accept && is_arith(opcode_in[7:4]) && !is_ind(opcode_in[3:0])
			&& opcode_in[3:0] == `IT_LO_DIR
			|=> timing_out.nbytes == `IT_B2 && timing_out.nclk == `IT_C2;
	endproperty
	a_dir_arith: assert property (p_dir_arith)
		else $error("direct arithmetic not two bytes two clocks");

	property p_reg_logic;
		accept && is_logic(opcode_in[7:4]) && opcode_in[3]
			|=> done_out && timing_out.cls == cls_logic;
	endproperty
	a_reg_logic: assert property (p_reg_logic)
		else $error("register logic op not one clock");

	property p_ind_logic;
		accept && is_logic(opcode_in[7:4]) && is_ind(opcode_in[3:0])
			|=> timing_out.nbytes == `IT_B1 && timing_out.nclk == `IT_C2;
	endproperty
	a_ind_logic: assert property (p_ind_logic)
		else $error("indirect logic op timing wrong");

	property p_dira_logic;
		accept && is_logic(opcode_in[7:4]) && opcode_in[3:0] == `IT_LO_DIRA
			|=> !done_out ##1 done_out;
	endproperty
	a_dira_logic: assert property (p_dira_logic)
		else $error("direct-from-accumulator logic op not two clocks");

	property p_dirimm_logic;
		accept && is_logic(opcode_in[7:4]) && opcode_in[3:0] == `IT_LO_DIRIMM
			|=> (!done_out)[*2] ##1 done_out;
	endproperty
	a_dirimm_logic: assert property (p_dirimm_logic)
		else $error("immediate-to-direct logic op not three clocks");

	property p_mul;
		accept && opcode_in == `IT_OP_MUL |=> (!done_out)[*3] ##1 done_out;
	endproperty
	a_mul: assert property (p_mul)
		else $error("multiply not four clocks");

	property p_div;
		accept && opcode_in == `IT_OP_DIV |=> (!done_out)[*7] ##1 done_out;
	endproperty
	a_div: assert property (p_div)
		else $error("divide not eight clocks");

	property p_max;
		accept |-> run_clk <= `IT_MAX_CLKS && run_clk != `IT_C0;
	endproperty
	a_max: assert property (p_max)
		else $error("instruction longer than eight clocks");

	property p_branch;
		accept && dec.cond |=> timing_out.nclk ==
			$past(dec.nclk) + {3'h0, $past(branch_taken_in)};
	endproperty
	a_branch: assert property (p_branch)
		else $error("taken branch not one clock longer");

	property p_count;
		state_r == st_busy |=> cnt_r == $past(cnt_r) - `IT_C1;
	endproperty
	a_count: assert property (p_count)
		else $error("cycle count did not step by one clock");

	property p_back2back;
		done_out && opcode_valid_in |=> busy_out;
	endproperty
	a_back2back: assert property (p_back2back)
		else $error("issue stalled after final clock");

	property p_misc_one;
		accept && (opcode_in == `IT_OP_INCDP || opcode_in == `IT_OP_DECADJ)
			|=> done_out && timing_out.nbytes == `IT_B1;
	endproperty
	a_misc_one: assert property (p_misc_one)
		else $error("pointer increment or decimal adjust not one clock");

	property p_illegal;
		accept |=> timing_out.illegal == ($past(opcode_in) == `IT_OP_RSVD);
	endproperty
	a_illegal: assert property (p_illegal)
		else $error("reserved opcode flag wrong");

endmodule

// file: verification/prog_mem_model.sv
// program memory model: hands the decoder one opcode per slot.
// assumes the bench picks the slot at the falling clock edge.
`timescale 1ns/100ps

module prog_mem_model (
	// slot select, top bit selects the linear code sweep
	input  wire logic [8:0] slot_in,
	// fetched opcode byte
	output logic      [7:0] opcode_out
);
	////////////////////////////////////////////////////////////////
	// one opcode per timed form, then two branches and the reserved code
	localparam logic [0:21][7:0] rom = {
		8'h28, 8'h26, 8'h25, 8'h24, 8'h38, 8'h97, 8'h04, 8'h1F,
		8'h06, 8'h58, 8'h45, 8'h64, 8'h57, 8'h42, 8'h63, 8'hA3,
		8'hD4, 8'hA4, 8'h84, 8'h40, 8'hB6, 8'hA5};

	// sweep mode returns the slot number itself, so all codes are reached
	assign opcode_out = slot_in[8] ? slot_in[7:0] : rom[slot_in[4:0]];
endmodule

// file: verification/tb_instr_timing.sv
// self-checking bench for the opcode timing decoder.
// assumes the program memory model supplies the offered opcode.
`timescale 1ns/100ps
`include "it_params.svh"

module tb_instr_timing;
	import it_pkg::*;

	////////////////////////////////////////////////////////////////
	// stimulus, observed outputs and counters
	logic       mclk_in         = 1'b0;
	logic       reset_in        = 1'b1;
	logic       opcode_valid_in = 1'b0;
	logic       branch_taken_in = 1'b0;
	logic [8:0] slot_in         = 9'h000;
	logic [7:0] opcode_in;
	logic       ready_out;
	timing_s    timing_out;
	logic [3:0] remain_out;
	logic       busy_out;
	logic       done_out;
	int         mismatches      = 0;
	int         compares        = 0;

	// expected bytes and clocks of the first nineteen program slots
	localparam logic [0:18][1:0] exp_b = {2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1,
		2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h2, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1};
	localparam logic [0:18][3:0] exp_c = {4'h1, 4'h2, 4'h2, 4'h2, 4'h1, 4'h2, 4'h1,
		4'h1, 4'h2, 4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h1, 4'h1, 4'h4, 4'h8};

	// 20 MHz system clock
	always #25 mclk_in = ~mclk_in;

	////////////////////////////////////////////////////////////////
	// design and far-side model
	instr_timing dut_u (
		.mclk_in         (mclk_in),
		.reset_in        (reset_in),
		.opcode_in       (opcode_in),
		.opcode_valid_in (opcode_valid_in),
		.branch_taken_in (branch_taken_in),
		.ready_out       (ready_out),
		.timing_out      (timing_out),
		.remain_out      (remain_out),
		.busy_out        (busy_out),
		.done_out        (done_out)
	);

	prog_mem_model mem_u (
		.slot_in    (slot_in),
		.opcode_out (opcode_in)
	);

	////////////////////////////////////////////////////////////////
	// shared compare and closing report
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// offer one slot at a falling edge, count clocks up to done;
	// bounded at ten so a stuck sequencer cannot hang the run
	task automatic run(input logic [8:0] s, input logic tk, output logic [3:0] n,
		output logic [3:0] r1);
		slot_in = s;
		branch_taken_in = tk;
		opcode_valid_in = 1'b1;
		@(negedge mclk_in);
		opcode_valid_in = 1'b0;
		r1 = remain_out;
		n = 4'h1;
		while (done_out !== 1'b1 && n < 4'hA) begin
			@(negedge mclk_in);
			n++;
		end
		if (done_out !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t ns: no completion", $time);
			summarize();
		end
	endtask

	////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		check(4'(ready_out), 4'h1);
		check(4'(busy_out | done_out | (|remain_out) | (|timing_out)), 4'h0);
		reset_in = 1'b0;
		@(negedge mclk_in);
		check(4'(ready_out), 4'h1);
		check(4'(busy_out), 4'h0);
		$display("test reset done");
	endtask

	task automatic t_table();
		logic [3:0] n;
		logic [3:0] r1;
		for (int i = 0; i < 19; i++) begin
			run(9'(i), 1'b0, n, r1);
			check(n, exp_c[i]);
			check(r1, exp_c[i]);
			check(4'(timing_out.nbytes), 4'(exp_b[i]));
		end
		$display("test table done");
	endtask

	// conditional branches, untaken then taken
	task automatic t_branch();
		logic [3:0] n;
		logic [3:0] r1;
		for (int t = 0; t < 2; t++) begin
			run(9'h013, t[0], n, r1);
			check(n, 4'h2 + 4'(t));
			check(4'(timing_out.cond), 4'h1);
			run(9'h014, t[0], n, r1);
			check(n, 4'h4 + 4'(t));
			// register count-down loop, fetched through the sweep path
			run(9'h1D8, t[0], n, r1);
			check(n, 4'h2 + 4'(t));
			check(4'(timing_out.nbytes), 4'h2);
		end
		$display("test branch done");
	endtask

	task automatic t_reserved();
		logic [3:0] n;
		logic [3:0] r1;
		run(9'h015, 1'b0, n, r1);
		check(4'(timing_out.illegal), 4'h1);
		check(n, 4'h1);
		$display("test reserved done");
	endtask

	// one-clock ops every cycle, then a divide offered while multiply runs
	task automatic t_b2b();
		slot_in = 9'h000;
		opcode_valid_in = 1'b1;
		repeat (3) begin
			@(negedge mclk_in);
			check(4'(done_out), 4'h1);
		end
		slot_in = 9'h011;
		@(negedge mclk_in);
		slot_in = 9'h012;
		repeat (3) @(negedge mclk_in);
		check(4'(done_out), 4'h1);
		check(timing_out.nclk, 4'h4);
		@(negedge mclk_in);
		opcode_valid_in = 1'b0;
		check(timing_out.nclk, 4'h8);
		check(remain_out, 4'h8);
		check(4'(ready_out & ~busy_out), 4'h0);
		repeat (7) @(negedge mclk_in);
		check(4'(done_out), 4'h1);
		$display("test back to back done");
	endtask

	// every opcode: measured clocks match the report, none above eight
	task automatic t_sweep();
		logic [3:0] n;
		logic [3:0] r1;
		int         ill;
		ill = 0;
		for (int i = 0; i < 256; i++) begin
			run({1'b1, 8'(i)}, 1'b0, n, r1);
			check(n, timing_out.nclk);
			check(4'(n <= `IT_MAX_CLKS), 4'h1);
			ill += int'(timing_out.illegal === 1'b1);
		end
		check(4'(ill), 4'h1);
		$display("test sweep done");
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (20) @(negedge mclk_in);
		t_reset();
		t_table();
		t_branch();
		t_reserved();
		t_b2b();
		t_sweep();
		summarize();
	end
endmodule
